/* pkg/ddc_mem_if.sv */
// memory access carrier between one serial slave and the shared sram
`timescale 1ns/10ps
interface ddc_mem_if;
    logic [11:0] ofs;
    logic hdcp;
    logic wr;
    logic [7:0] wdata;
    logic [7:0] rdata;
    modport slv (output ofs, output hdcp, output wr, output wdata, input rdata);
    modport mem (input ofs, input hdcp, input wr, input wdata, output rdata);
endinterface

/* pkg/ddc_pkg.sv */
// shared constants for the display-data-channel edid server
package ddc_pkg;
    localparam int NUM_HDMI = 4;
    localparam int NUM_DDC = 5;
    localparam int NUM_PORTS = 6;
    localparam int LOCAL_PORT = 5;
    localparam int VGA_PORT = 4;
    localparam int MEM_BYTES = 2176;
    localparam int REGION_BYTES = 256;
    localparam int KSV_SLICE = 128;
    // sram map, byte addresses
    localparam logic [11:0] VGA_BASE = 12'h500;
    localparam logic [11:0] KSV_BASE = 12'h580;
    localparam logic [11:0] PRELOAD_BASE = 12'h800;
    localparam logic [11:0] RSVD_BASE = 12'h840;
    localparam logic [11:0] HDMI_END = 12'h400;
    // non-volatile store map
    localparam logic [8:0] NV_VGA_BASE = 9'h100;
    localparam logic [8:0] NV_PRE_BASE = 9'h180;
    localparam logic [8:0] NV_UNUSED_BASE = 9'h1c0;
    localparam logic [9:0] BOOT_COUNT = 10'h200;
    // preload bytes holding hot-plug states and mobile-link port
    localparam logic [5:0] PRE_HPD_OFS = 6'h00;
    localparam logic [5:0] PRE_MOB_OFS = 6'h01;
    localparam int HPD_LSB = 0;
    localparam int MOB_LSB = 0;
    // 7-bit bus addresses (0xa0 and 0x74 as 8-bit write addresses)
    localparam logic [6:0] EDID_DEV = 7'h50;
    localparam logic [6:0] HDCP_DEV = 7'h3a;
    localparam logic [6:0] LOCAL_DEV = 7'h30;

    typedef enum logic [6:0] {
        ST_IDLE = 7'b0000001,
        ST_ADDR = 7'b0000010,
        ST_OFS = 7'b0000100,
        ST_WDAT = 7'b0001000,
        ST_ACK = 7'b0010000,
        ST_RDAT = 7'b0100000,
        ST_MACK = 7'b1000000
    } slave_st_t;
endpackage

/* rtl/ddc_edid_server.sv */
// always-on edid and hdcp serving front end for five ddc ports and a local port
`timescale 1ns/10ps
//
// Operation
// RULE1 - five slave-only ddc ports, up to 400 khz
// RULE2 - answer 0xa0 edid and 0x74 hdcp
// RULE3 - each port serves exactly one e-ddc bus
// RULE4 - sram of 2176 bytes, fixed region map
// RULE5 - all ports read own regions concurrently
// RULE6 - local port writes, ddc ports only read
// RULE7 - 512-byte nonvolatile store with fixed layout
// RULE8 - boot copies edid, hpd states, mobile port
// RULE9 - software programs nonvolatile store at manufacture
// RULE10 - hdcp register accesses over ddc acted on; the code serves hdcp reads from each port's ksv slice and drops ddc writes
// RULE11 - secret keys never returned on reads
// RULE12 - control registers only through local port
// RULE13 - independent hot-plug output per hdmi port
// RULE14 - offset advances per byte within region
// RULE15 - no edid answers before boot copy ends
module ddc_edid_server #(
    parameter logic [6:0] LOCAL_ADDR = ddc_pkg::LOCAL_DEV
) (
    input wire logic ref_clk_i,
    input wire logic rst_b_i,
    input wire logic [ddc_pkg::NUM_DDC-1:0] ddc_scl_i,
    input wire logic [ddc_pkg::NUM_DDC-1:0] ddc_sda_i,
    output logic [ddc_pkg::NUM_DDC-1:0] ddc_sda_o,
    output logic [ddc_pkg::NUM_DDC-1:0] ddc_sda_oe_o,
    input wire logic loc_scl_i,
    input wire logic loc_sda_i,
    output logic loc_sda_o,
    output logic loc_sda_oe_o,
    output logic [8:0] nv_addr_o,
    input wire logic [7:0] nv_data_i,
    output logic [ddc_pkg::NUM_HDMI-1:0] hpd_o,
    output logic [1:0] mobile_port_o,
    output logic boot_done_o
);
    import ddc_pkg::*;

    logic [7:0] mem_q [MEM_BYTES];
    logic [9:0] boot_cnt_q;
    logic [8:0] boot_a_q;
    logic boot_v_q, boot_done_q;
    logic [NUM_HDMI-1:0] hpd_q;
    logic [1:0] mobile_q;
    logic [NUM_PORTS-1:0] sda_lvl_q;
    logic [NUM_PORTS-1:0] oe_w;
    logic [NUM_PORTS-1:0] scl_w, sda_w;

    ddc_mem_if mif [NUM_PORTS] ();

    ////////////////////////////////////////////////////////////////////////////
    // serial slaves: five read-only ddc ports, one read-write local port

    assign scl_w = {loc_scl_i, ddc_scl_i};
    assign sda_w = {loc_sda_i, ddc_sda_i};

    for (genvar p = 0; p < NUM_PORTS; p++) begin : g_port
        localparam bit IS_LOC = (p == LOCAL_PORT);
        // one engine per external bus, no sharing between buses
        ddc_slave #( // [RULE1] [RULE3]
            .DEV_A(IS_LOC ? LOCAL_ADDR : EDID_DEV),
            .DEV_B(IS_LOC ? LOCAL_ADDR : HDCP_DEV),
            .OFS_BYTES(IS_LOC ? 2 : 1),
            .WR_EN(IS_LOC)
        ) u_slave (
            .ref_clk_i(ref_clk_i),
            .rst_b_i(rst_b_i),
            .scl_i(scl_w[p]),
            .sda_i(sda_w[p]),
            .ready_i(boot_done_q),
            .sda_oe_o(oe_w[p]),
            .mem(mif[p])
        );
    end

    ////////////////////////////////////////////////////////////////////////////
    // per-port read selection; every port has its own mux so none stalls

    for (genvar p = 0; p < NUM_DDC; p++) begin : g_rd
        localparam logic [11:0] EBASE = 12'(p * REGION_BYTES);
        localparam logic [11:0] KBASE = 12'(p * KSV_SLICE);
        wire [11:0] ksv_idx = KSV_BASE + KBASE + {5'h00, mif[p].ofs[6:0]};
        // vga port wraps inside its 128-byte block
        wire [11:0] edid_idx = (p == VGA_PORT) ? VGA_BASE + {5'h00, mif[p].ofs[6:0]}
                                               : EBASE + {4'h0, mif[p].ofs[7:0]}; // [RULE14]
        wire [11:0] rd_idx = mif[p].hdcp ? ksv_idx : edid_idx; // [RULE10]
        assign mif[p].rdata = mem_q[rd_idx]; // [RULE5]
    end

    // key material has no storage here, so no read path can reach it
    wire loc_in_map = mif[LOCAL_PORT].ofs < 12'(MEM_BYTES); // [RULE11]
    assign mif[LOCAL_PORT].rdata = loc_in_map ? mem_q[mif[LOCAL_PORT].ofs] : 8'h00;

    ////////////////////////////////////////////////////////////////////////////
    // boot copy from the non-volatile store, one byte per clock

    wire boot_edid = boot_v_q & (boot_a_q < NV_VGA_BASE);
    wire boot_vga = boot_v_q & (boot_a_q >= NV_VGA_BASE) & (boot_a_q < NV_PRE_BASE);
    wire boot_pre = boot_v_q & (boot_a_q >= NV_PRE_BASE) & (boot_a_q < NV_UNUSED_BASE);
    wire boot_hpd = boot_pre & (boot_a_q[5:0] == PRE_HPD_OFS);
    wire boot_mob = boot_pre & (boot_a_q[5:0] == PRE_MOB_OFS);

    always_ff @(posedge ref_clk_i) begin
        if (!rst_b_i) begin
            boot_cnt_q <= 10'h000;
            boot_a_q <= 9'h000;
            boot_v_q <= 1'b0;
            boot_done_q <= 1'b0;
        end else begin
            // store answers one clock after the address
            boot_v_q <= boot_cnt_q < BOOT_COUNT; // [RULE7]
            boot_a_q <= boot_cnt_q[8:0];
            if (boot_cnt_q < BOOT_COUNT) boot_cnt_q <= boot_cnt_q + 10'h001;
            boot_done_q <= boot_cnt_q == BOOT_COUNT; // [RULE8]
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // sram storage; only boot and the local port write

    wire loc_wr = mif[LOCAL_PORT].wr; // [RULE6]
    wire [11:0] loc_ofs = mif[LOCAL_PORT].ofs;
    wire [7:0] loc_wdata = mif[LOCAL_PORT].wdata;

    for (genvar j = 0; j < MEM_BYTES; j++) begin : g_mem
        localparam logic [11:0] JA = 12'(j);
        // common edid lands in all four hdmi regions at once
        wire hit_edid = boot_edid & (JA < HDMI_END) & (JA[7:0] == boot_a_q[7:0]); // [RULE4]
        wire hit_vga = boot_vga & (JA >= VGA_BASE) & (JA < KSV_BASE)
                       & (JA[6:0] == boot_a_q[6:0]);
        wire hit_pre = boot_pre & (JA >= PRELOAD_BASE) & (JA < RSVD_BASE)
                       & (JA[5:0] == boot_a_q[5:0]);
        wire hit_boot = hit_edid | hit_vga | hit_pre; // [RULE8]
        wire hit_loc = loc_wr & (loc_ofs == JA);
        always_ff @(posedge ref_clk_i) begin
            if (!rst_b_i) begin
                mem_q[j] <= 8'h00;
            end else if (hit_boot) begin
                mem_q[j] <= nv_data_i;
            end else if (hit_loc) begin
                mem_q[j] <= loc_wdata;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // hot-plug and mobile-port controls, loaded at boot, later written only from the local port

    wire loc_hpd = loc_wr & (loc_ofs == PRELOAD_BASE + {6'h00, PRE_HPD_OFS}); // [RULE12]
    wire loc_mob = loc_wr & (loc_ofs == PRELOAD_BASE + {6'h00, PRE_MOB_OFS}); // [RULE12]

    always_ff @(posedge ref_clk_i) begin
        if (!rst_b_i) begin
            hpd_q <= 4'h0;
            mobile_q <= 2'h0;
            sda_lvl_q <= 6'h00;
        end else begin
            // one bit per port, all set from one byte
            if (boot_hpd) hpd_q <= nv_data_i[HPD_LSB +: NUM_HDMI]; // [RULE8]
            else if (loc_hpd) hpd_q <= loc_wdata[HPD_LSB +: NUM_HDMI]; // [RULE13]
            if (boot_mob) mobile_q <= nv_data_i[MOB_LSB +: 2]; // [RULE8]
            else if (loc_mob) mobile_q <= loc_wdata[MOB_LSB +: 2];
            // open-drain pins only ever pull low
            sda_lvl_q <= 6'h00;
        end
    end

    assign ddc_sda_o = sda_lvl_q[NUM_DDC-1:0];
    assign loc_sda_o = sda_lvl_q[LOCAL_PORT];
    assign ddc_sda_oe_o = oe_w[NUM_DDC-1:0];
    assign loc_sda_oe_o = oe_w[LOCAL_PORT];
    assign nv_addr_o = boot_cnt_q[8:0];
    assign hpd_o = hpd_q;
    assign mobile_port_o = mobile_q;
    assign boot_done_o = boot_done_q;

    ////////////////////////////////////////////////////////////////////////////
    // checks

    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (!rst_b_i);

    sequence s_last_copy;
        boot_v_q && (boot_a_q == 9'h1ff);
    endsequence
    sequence s_vga_first;
        boot_v_q && (boot_a_q == NV_VGA_BASE);
    endsequence

    a_boot_done_end: assert property (s_last_copy |=> boot_done_q ##1 boot_done_q) // [RULE8]
        else $error("boot not done after last copy");
    a_ddc_quiet_boot: assert property (!boot_done_q |-> (ddc_sda_oe_o == 5'h00)) // [RULE15]
        else $error("ddc pin driven before boot done");
    a_vga_copy_lands: assert property ( // [RULE7]
        s_vga_first |=> mem_q[VGA_BASE] == $past(nv_data_i))
        else $error("vga edid byte not copied");
    a_edid_fanout: assert property ( // [RULE4]
        boot_v_q && (boot_a_q == 9'h005)
            |=> (mem_q[12'h305] == $past(nv_data_i)) && (mem_q[12'h005] == $past(nv_data_i)))
        else $error("common edid not copied to every region");
    a_hpd_own_bits: assert property ( // [RULE13]
        loc_hpd && !boot_hpd |=> hpd_q == $past(loc_wdata[3:0]))
        else $error("hot-plug outputs not set from local write");
    a_mobile_boot: assert property ( // [RULE8]
        boot_mob |=> mobile_port_o == $past(nv_data_i[1:0]))
        else $error("mobile port not loaded at boot");
endmodule // ddc_edid_server

/* rtl/ddc_slave.sv */
// i2c slave engine with pin filtering and byte-offset memory access
`timescale 1ns/10ps
module ddc_slave #(
    parameter logic [6:0] DEV_A = 7'h50,
    parameter logic [6:0] DEV_B = 7'h3a,
    parameter int OFS_BYTES = 1,
    parameter bit WR_EN = 1'b0
) (
    input wire logic ref_clk_i,
    input wire logic rst_b_i,
    input wire logic scl_i,
    input wire logic sda_i,
    input wire logic ready_i,
    output logic sda_oe_o,
    ddc_mem_if.slv mem
);
    import ddc_pkg::*;

    logic [2:0] scl_s_q, sda_s_q;
    logic scl_f_q, sda_f_q, scl_p_q, sda_p_q;
    slave_st_t st_q, nxt_q;
    logic [3:0] cnt_q;
    logic [7:0] sh_q;
    logic [11:0] ofs_q;
    logic hdcp_q, obyte_q, oe_q, wr_q, mack_q;

    // change accepted only once second and third stage agree
    always_ff @(posedge ref_clk_i) begin
        if (!rst_b_i) begin
            scl_s_q <= 3'h7;
            sda_s_q <= 3'h7;
            scl_f_q <= 1'b1;
            sda_f_q <= 1'b1;
            scl_p_q <= 1'b1;
            sda_p_q <= 1'b1;
        end else begin
            scl_s_q <= {scl_s_q[1:0], scl_i};
            sda_s_q <= {sda_s_q[1:0], sda_i};
            if (scl_s_q[1] == scl_s_q[2]) scl_f_q <= scl_s_q[2];
            if (sda_s_q[1] == sda_s_q[2]) sda_f_q <= sda_s_q[2];
            scl_p_q <= scl_f_q;
            sda_p_q <= sda_f_q;
        end
    end

    wire scl_rise = scl_f_q & ~scl_p_q;
    wire scl_fall = ~scl_f_q & scl_p_q;
    wire start_c = scl_f_q & scl_p_q & sda_p_q & ~sda_f_q;
    wire stop_c = scl_f_q & scl_p_q & ~sda_p_q & sda_f_q;
    wire byte_done = scl_fall & (cnt_q == 4'h8);
    wire addr_hit = (sh_q[7:1] == DEV_A) | (sh_q[7:1] == DEV_B); // [RULE2]
    wire ofs_last = (OFS_BYTES == 1) | obyte_q;
    wire [11:0] ofs_nxt = (OFS_BYTES == 2) ? {ofs_q[3:0], sh_q} : {4'h0, sh_q};

    assign mem.ofs = ofs_q;
    assign mem.hdcp = hdcp_q;
    assign mem.wdata = sh_q;
    assign mem.wr = wr_q & WR_EN; // [RULE6]
    assign sda_oe_o = oe_q;

    always_ff @(posedge ref_clk_i) begin
        if (!rst_b_i) begin
            st_q <= ST_IDLE;
            nxt_q <= ST_IDLE;
            cnt_q <= 4'h0;
            sh_q <= 8'h00;
            ofs_q <= 12'h000;
            hdcp_q <= 1'b0;
            obyte_q <= 1'b0;
            oe_q <= 1'b0;
            wr_q <= 1'b0;
            mack_q <= 1'b0;
        end else begin
            wr_q <= 1'b0;
            if (wr_q) ofs_q <= ofs_q + 12'h001; // [RULE14]
            if (start_c) begin
                st_q <= ST_ADDR;
                cnt_q <= 4'h0;
                oe_q <= 1'b0;
            end else if (stop_c) begin
                st_q <= ST_IDLE;
                oe_q <= 1'b0;
            end else begin
                case (st_q)
                    ST_ADDR, ST_OFS, ST_WDAT: begin
                        if (scl_rise) begin
                            sh_q <= {sh_q[6:0], sda_f_q};
                            cnt_q <= cnt_q + 4'h1;
                        end else if (byte_done) begin
                            cnt_q <= 4'h0;
                            oe_q <= 1'b1;
                            st_q <= ST_ACK;
                            if (st_q == ST_ADDR) begin
                                // not ready before boot copy: address is not acknowledged
                                if (!(ready_i && addr_hit)) begin // [RULE15]
                                    oe_q <= 1'b0;
                                    st_q <= ST_IDLE;
                                end
                                hdcp_q <= (sh_q[7:1] == DEV_B) && (DEV_A != DEV_B); // [RULE10]
                                nxt_q <= sh_q[0] ? ST_RDAT : ST_OFS;
                                obyte_q <= 1'b0;
                            end else if (st_q == ST_OFS) begin
                                ofs_q <= ofs_nxt;
                                nxt_q <= ofs_last ? ST_WDAT : ST_OFS;
                                obyte_q <= ~obyte_q;
                            end else begin
                                // data from a read-only port is acknowledged and dropped
                                wr_q <= 1'b1;
                                nxt_q <= ST_WDAT;
                            end
                        end
                    end
                    ST_ACK: begin
                        if (scl_fall) begin
                            cnt_q <= 4'h0;
                            st_q <= nxt_q;
                            sh_q <= mem.rdata;
                            oe_q <= (nxt_q == ST_RDAT) & ~mem.rdata[7];
                        end
                    end
                    ST_RDAT: begin
                        if (scl_fall) begin
                            if (cnt_q == 4'h7) begin
                                oe_q <= 1'b0;
                                st_q <= ST_MACK;
                                ofs_q <= ofs_q + 12'h001; // [RULE14]
                            end else begin
                                sh_q <= {sh_q[6:0], 1'b0};
                                oe_q <= ~sh_q[6];
                                cnt_q <= cnt_q + 4'h1;
                            end
                        end
                    end
                    ST_MACK: begin
                        if (scl_rise) begin
                            mack_q <= ~sda_f_q;
                        end else if (scl_fall) begin
                            cnt_q <= 4'h0;
                            sh_q <= mem.rdata;
                            oe_q <= mack_q & ~mem.rdata[7];
                            st_q <= mack_q ? ST_RDAT : ST_IDLE;
                        end
                    end
                    default: st_q <= ST_IDLE;
                endcase
            end
        end
    end

    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (!rst_b_i);

    a_nack_before_boot: assert property ( // [RULE15]
        (st_q == ST_ADDR) && byte_done && !start_c && !stop_c && !ready_i
            |=> (st_q == ST_IDLE) && !oe_q)
        else $error("address acknowledged while not ready");
    a_addr_ack_drive: assert property ( // [RULE2]
        (st_q == ST_ADDR) && byte_done && !start_c && !stop_c && ready_i && addr_hit
            |=> (st_q == ST_ACK) && oe_q)
        else $error("matching address not acknowledged");
    a_read_advance: assert property ( // [RULE14]
        (st_q == ST_RDAT) && scl_fall && (cnt_q == 4'h7) && !start_c && !stop_c
            |=> ofs_q == $past(ofs_q) + 12'h001)
        else $error("offset did not advance after read byte");
    a_port_readonly: assert property ( // [RULE6]
        !WR_EN |-> !mem.wr)
        else $error("write strobe on read-only port");
endmodule // ddc_slave

/* test/ddc_edid_memory_server_bench.sv */
// self-checking bench for the ddc edid server, bench acts as every bus master
`timescale 1ns/10ps
module ddc_edid_memory_server_bench;
    import ddc_pkg::*;
    // third of a bit in clocks, well above the slave's filter delay
    localparam int Q = 12;
    logic ref_clk_i = 1'b0;
    logic rst_b_i = 1'b0;
    logic [5:0] m_scl = 6'h3f;
    logic [5:0] m_sda = 6'h3f;
    logic [5:0] ln;
    logic [4:0] sda_o;
    logic [4:0] sda_oe;
    logic loc_o;
    logic loc_oe;
    logic [8:0] nv_addr;
    logic [7:0] nv_data;
    logic [3:0] hpd;
    logic [1:0] mob;
    logic done;
    int fails = 0;
    int total_checks = 0;

    always #2 ref_clk_i = ~ref_clk_i;
    // open-drain wires: whoever pulls low wins over the pull-up
    assign ln = m_sda & ~{loc_oe, sda_oe};

    ddc_edid_server i_dut (.ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i), .ddc_scl_i(m_scl[4:0]),
        .ddc_sda_i(ln[4:0]), .ddc_sda_o(sda_o), .ddc_sda_oe_o(sda_oe), .loc_scl_i(m_scl[5]),
        .loc_sda_i(ln[5]), .loc_sda_o(loc_o), .loc_sda_oe_o(loc_oe), .nv_addr_o(nv_addr),
        .nv_data_i(nv_data), .hpd_o(hpd), .mobile_port_o(mob), .boot_done_o(done));
    ddc_nv_model i_nv (.ref_clk_i(ref_clk_i), .addr_i(nv_addr), .data_o(nv_data));

    ////////////////////////////////////////////////////////////////////////////////
    task automatic hc(input int n);
        repeat (n) @(negedge ref_clk_i);
    endtask

    // expected store contents, kept apart from the partner model on purpose
    function automatic logic [7:0] nv_exp(input logic [8:0] a);
        return a[7:0] ^ (a[8] ? 8'hc3 : 8'h3c);
    endfunction

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        total_checks++;
        if (seen !== exp) begin
            fails++;
            $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic fin(input string name);
        $display("test %s finished", name);
    endtask

    task automatic stop_test();
        $display("checks %0d mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    task automatic bitx(input int p, input logic v, output logic s);
        m_sda[p] = v;
        hc(Q);
        m_scl[p] = 1'b1;
        hc(Q);
        s = ln[p];
        m_scl[p] = 1'b0;
        hc(Q);
    endtask

    // also serves as repeated start, since scl is low between bytes
    task automatic sta(input int p);
        m_sda[p] = 1'b1;
        hc(Q);
        m_scl[p] = 1'b1;
        hc(Q);
        m_sda[p] = 1'b0;
        hc(Q);
        m_scl[p] = 1'b0;
        hc(Q);
    endtask

    task automatic sto(input int p);
        m_sda[p] = 1'b0;
        hc(Q);
        m_scl[p] = 1'b1;
        hc(Q);
        m_sda[p] = 1'b1;
        hc(Q);
    endtask

    // writing 8'hff releases the wire so the slave can drive read data
    task automatic bytex(input int p, input logic [7:0] wb, input logic ackm,
                         output logic [7:0] rb, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bitx(p, wb[i], s);
            rb[i] = s;
        end
        bitx(p, ackm, s);
        ack = ~s;
    endtask

    task automatic addr_only(input int p, input logic [7:0] a, output logic k);
        logic [7:0] x;
        sta(p);
        bytex(p, a, 1'b1, x, k);
        sto(p);
    endtask

    task automatic rd2(input int p, input logic [6:0] dev, input logic [7:0] ofs,
                       input logic [15:0] exp);
        logic [7:0] b0, b1, x;
        logic a0, a1, a2, n;
        sta(p);
        bytex(p, {dev, 1'b0}, 1'b1, x, a0);
        bytex(p, ofs, 1'b1, x, a1);
        sta(p);
        bytex(p, {dev, 1'b1}, 1'b1, x, a2);
        bytex(p, 8'hff, 1'b0, b0, n);
        bytex(p, 8'hff, 1'b1, b1, n);
        sto(p);
        check({13'h0, a0, a1, a2}, 16'h7);
        check({b0, b1}, exp);
    endtask

    task automatic lwr(input logic [11:0] a, input logic [7:0] d);
        logic [7:0] x;
        logic k0, k1, k2, k3;
        sta(5);
        bytex(5, {LOCAL_DEV, 1'b0}, 1'b1, x, k0);
        bytex(5, {4'h0, a[11:8]}, 1'b1, x, k1);
        bytex(5, a[7:0], 1'b1, x, k2);
        bytex(5, d, 1'b1, x, k3);
        sto(5);
        check({12'h0, k0, k1, k2, k3}, 16'hf);
    endtask

    task automatic lrd(input logic [11:0] a, input logic [7:0] exp);
        logic [7:0] x, b;
        logic k;
        sta(5);
        bytex(5, {LOCAL_DEV, 1'b0}, 1'b1, x, k);
        bytex(5, {4'h0, a[11:8]}, 1'b1, x, k);
        bytex(5, a[7:0], 1'b1, x, k);
        sta(5);
        bytex(5, {LOCAL_DEV, 1'b1}, 1'b1, x, k);
        bytex(5, 8'hff, 1'b1, b, k);
        sto(5);
        check({8'h0, b}, {8'h0, exp});
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_boot();
        logic k;
        logic [7:0] v;
        addr_only(0, {EDID_DEV, 1'b0}, k);
        check({15'h0, k}, 16'h0);
        check({15'h0, done}, 16'h0);
        repeat (600) if (done !== 1'b1) hc(1);
        check({15'h0, done}, 16'h1);
        v = nv_exp(9'h180);
        check({12'h0, hpd}, {12'h0, v[3:0]});
        v = nv_exp(9'h181);
        check({14'h0, mob}, {14'h0, v[1:0]});
        fin("boot");
    endtask

    // top of each region, so the second byte shows the wrap
    task automatic edid_port(input int p);
        if (p < NUM_HDMI) begin
            rd2(p, EDID_DEV, 8'hff, {nv_exp(9'h0ff), nv_exp(9'h000)});
        end else begin
            rd2(p, EDID_DEV, 8'h7f, {nv_exp(9'h17f), nv_exp(9'h100)});
        end
    endtask

    task automatic t_edid();
        for (int p = 0; p < NUM_DDC; p++) begin
            fork
                automatic int q = p;
                edid_port(q);
            join_none
        end
        wait fork;
        fin("edid");
    endtask

    task automatic t_refuse();
        logic k;
        addr_only(1, 8'h42, k);
        check({15'h0, k}, 16'h0);
        addr_only(2, {LOCAL_DEV, 1'b0}, k);
        check({15'h0, k}, 16'h0);
        fin("refuse");
    endtask

    task automatic t_write();
        logic [7:0] x;
        logic k0, k1, k2;
        lwr(12'h120, 8'ha5);
        rd2(1, EDID_DEV, 8'h20, {8'ha5, nv_exp(9'h021)});
        rd2(0, EDID_DEV, 8'h20, {nv_exp(9'h020), nv_exp(9'h021)});
        lrd(12'h120, 8'ha5);
        // ddc data bytes are acked but must not land in memory
        sta(0);
        bytex(0, {EDID_DEV, 1'b0}, 1'b1, x, k0);
        bytex(0, 8'h30, 1'b1, x, k1);
        bytex(0, 8'h99, 1'b1, x, k2);
        sto(0);
        check({13'h0, k0, k1, k2}, 16'h7);
        rd2(0, EDID_DEV, 8'h30, {nv_exp(9'h030), nv_exp(9'h031)});
        fin("write");
    endtask

    task automatic t_hpd();
        lwr(12'h800, 8'h05);
        check({12'h0, hpd}, 16'h5);
        lwr(12'h800, 8'h0a);
        check({12'h0, hpd}, 16'ha);
        lwr(12'h801, 8'h01);
        check({14'h0, mob}, 16'h1);
        fin("hpd");
    endtask

    task automatic t_hdcp();
        lwr(12'h690, 8'h3c);
        rd2(2, HDCP_DEV, 8'h10, 16'h3c00);
        rd2(0, HDCP_DEV, 8'h10, 16'h0000);
        // past the end of the map the local read must give zero, not unknown
        lrd(12'h8ff, 8'h00);
        check({10'h0, sda_o, loc_o}, 16'h0);
        fin("hdcp");
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        hc(5);
        rst_b_i = 1'b1;
        t_boot();
        t_edid();
        t_refuse();
        t_write();
        t_hpd();
        t_hdcp();
        stop_test();
    end

    // run needs about 24k clocks; two and a half times that means a hang
    initial begin
        hc(60000);
        fails++;
        stop_test();
    end
endmodule // ddc_edid_memory_server_bench

/* test/ddc_nv_model.sv */
// behavioural non-volatile store with a one-clock synchronous read
`timescale 1ns/10ps
module ddc_nv_model (
    input wire logic ref_clk_i,
    input wire logic [8:0] addr_i,
    output logic [7:0] data_o
);
    // fixed pattern stands in for what software programs at manufacture
    function automatic logic [7:0] nv_val(input logic [8:0] a);
        return a[7:0] ^ (a[8] ? 8'hc3 : 8'h3c);
    endfunction

    // common edid, vga edid, preload and unused areas all readable
    always_ff @(posedge ref_clk_i) begin
        data_o <= nv_val(addr_i);
    end
endmodule // ddc_nv_model
